/* hdl/sfm_params.svh */
// constants of the safety fault monitor
`ifndef SFM_PARAMS_SVH
`define SFM_PARAMS_SVH
`define SFM_CODE_NONE 8'h00
`define SFM_CODE_INIT_CH1 8'h90
`define SFM_CODE_INIT_CH2 8'h91
`define SFM_CODE_INT_A 8'ha0
`define SFM_CODE_ENC_TOL 8'ha1
`define SFM_CODE_ENC_DIR 8'ha2
`define SFM_CODE_UNDEF_IN 8'ha3
`define SFM_CODE_INT_B 8'ha4
`define SFM_CODE_CASE_ORD 8'ha5
`define SFM_CODE_SENSOR0 8'hb4
`define SFM_CODE_PAIR0 8'hc8
`define SFM_CODE_IN_OPER 8'hcc
`define SFM_CODE_RESTART_INPUT_CH_A 8'hce
`define SFM_CODE_RESTART_INPUT_CH_B 8'hd0
`define SFM_CODE_ENC_FREQ 8'hd1
`define SFM_CODE_CONTACTOR_FEEDBACK_CH_A_OPEN 8'hf0
`define SFM_CODE_CONTACTOR_FEEDBACK_CH_A_CLOSED 8'hf2
`define SFM_CODE_CONTACTOR_FEEDBACK_CH_A_OPENINACT 8'hf3
`define SFM_CODE_CONTACTOR_FEEDBACK_CH_B_OPEN 8'hf4
`define SFM_CODE_CONTACTOR_FEEDBACK_CH_B_CLOSED 8'hf6
`define SFM_CODE_CONTACTOR_FEEDBACK_CH_B_OPENINACT 8'hf7
`define SFM_CODE_PROT_FIELD 8'hf8
`define SFM_CODE_WARN_FIELD 8'hf9
`define SFM_CODE_INT_C 8'hfa
// clock 20 MHz: period in ns
`define SFM_CLK_PERIOD_NS 50
// encoder pulse limit 100 kHz: least period 10000 ns
`define SFM_ENC_MIN_PERIOD_NS 10000
`define SFM_ENC_MIN_CYC ((`SFM_ENC_MIN_PERIOD_NS) / (`SFM_CLK_PERIOD_NS))
// tolerance margin in percent
`define SFM_TOL_PCT 25
// restart pulse least and longest time, contactor settle time
`define SFM_RES_MIN_NS 5000
`define SFM_RES_MIN_CYC \
  (((`SFM_RES_MIN_NS) + (`SFM_CLK_PERIOD_NS) - 1) / (`SFM_CLK_PERIOD_NS))
`define SFM_RES_MAX_NS 200000
`define SFM_RES_MAX_CYC ((`SFM_RES_MAX_NS) / (`SFM_CLK_PERIOD_NS))
`define SFM_EDM_NS 100000
`define SFM_EDM_CYC ((`SFM_EDM_NS) / (`SFM_CLK_PERIOD_NS))
`endif

/* hdl/sfm_pkg.sv */
// types of the safety fault monitor
package sfm_pkg;
  typedef logic [7:0] sfm_code_t;
  typedef struct packed {
    logic [11:0] period;
    logic [15:0] count;
    logic lastPulse;
  } sfm_enc_t;
  typedef struct packed {
    logic [15:0] count;
    logic lastLevel;
  } sfm_res_t;
endpackage

/* hdl/sfm_enc_chan.sv */
// one incremental encoder channel: pulse count, period and overspeed
`timescale 1ns/1ps
`include "sfm_params.svh"
module sfm_enc_chan
  import sfm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pulse,
  input wire logic clearCount,
  output logic [15:0] count,
  output logic tooFast
);
  typedef struct packed {
    sfm_enc_t enc;
    logic fast;
  } sfm_encst_t;
  sfm_encst_t st_q, st_d;
  logic rise;
  assign rise = pulse & ~st_q.enc.lastPulse;
  always_comb begin
    st_d = st_q;
    st_d.enc.lastPulse = pulse;
    st_d.fast = 1'b0;
    if (st_q.enc.period != 12'hfff) begin
      st_d.enc.period = st_q.enc.period + 12'h001;
    end
    if (rise) begin
      // edges no farther apart than the least period mean overspeed
      if (st_q.enc.period < 12'(`SFM_ENC_MIN_CYC)) begin
        st_d.fast = 1'b1;
      end
      st_d.enc.period = 12'h000;
      st_d.enc.count = st_q.enc.count + 16'h0001;
    end
    if (clearCount) begin
      st_d.enc.count = {15'h0000, rise};
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '{enc: '{period: 12'hfff, count: 16'h0000,
                       lastPulse: 1'b0}, fast: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end
  assign count = st_q.enc.count;
  assign tooFast = st_q.fast;
endmodule

/* hdl/sfm_monitor.sv */
// safety fault monitor top: checks inputs and reports fault codes
// ----------------------------------------------------------------
// Functional notes
// - encoder counts disagreeing beyond 125 percent of tolerance give 161.
// - encoders showing different travel directions give 162.
// - an input combination outside the defined set gives 163.
// - a case switch not allowed by the case order gives 165.
// - a dual input pair A to D at equal levels gives 200 to 203.
// - binary inputs operated invalidly give 204.
// - a restart pulse too short or too long gives 206 or 208.
// - encoder pulses at or above 100 kHz give 209.
// - contactor feedback still open after settle time gives 240 or 244.
// - feedback closed while the safety output is active gives 242 or 246.
// - feedback open while the safety output is inactive gives 243 or 247.
// - protective field object gives 248, warning field object gives 249.
// - sensor errors give 180 to 183, each kept in its own memory.
// - init failure of channel 1 or 2 gives 144 or 145.
// - internal errors give 160, 164, 250 and stay until reset.
// ----------------------------------------------------------------
`timescale 1ns/1ps
`include "sfm_params.svh"
module sfm_monitor
  import sfm_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] dualFirst,
  input wire logic [3:0] dualSecond,
  input wire logic [15:0] definedCombos,
  input wire logic [3:0] caseSelect,
  input wire logic [15:0] allowedNext,
  input wire logic caseStrobe,
  input wire logic restart_input_ch_a,
  input wire logic restart_input_ch_b,
  input wire logic encPulse1,
  input wire logic encPulse2,
  input wire logic encDir1,
  input wire logic encDir2,
  input wire logic encWindow,
  input wire logic [15:0] encTolerance,
  input wire logic contactor_feedback_ch_a,
  input wire logic contactor_feedback_ch_b,
  input wire logic safetyOutA,
  input wire logic safetyOutB,
  input wire logic protFieldObj,
  input wire logic warnFieldObj,
  input wire logic [3:0] sensorErr,
  input wire logic [1:0] initFail,
  input wire logic [2:0] internalErr,
  input wire logic [1:0] sensorQuery,
  input wire logic clearFault,
  output logic [7:0] faultCode,
  output logic [3:0] sensorMem,
  output logic latchedInternal
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    sfm_code_t code;
    logic [3:0] sensMem;
    logic [2:0] intErr;
    logic [3:0] lastCase;
    sfm_res_t resA;
    sfm_res_t resB;
    logic [15:0] edmA;
    logic [15:0] edmB;
    logic lastOutA;
    logic lastOutB;
    logic [3:0] pairBad;
    logic [3:0] lastFirst;
    logic armed;
  } sfm_state_t;
  sfm_state_t st_q, st_d;
  logic [15:0] cnt1, cnt2;
  logic fast1, fast2;
  logic [16:0] diff;
  logic [17:0] limit;
  // ----------------------------------------------------------------
  // encoders
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : gEnc
      if (gi == 0) begin : gA
        sfm_enc_chan uEnc (.mclk(mclk), .rst_n(rst_n), .pulse(encPulse1),
          .clearCount(encWindow), .count(cnt1), .tooFast(fast1));
      end else begin : gB
        sfm_enc_chan uEnc (.mclk(mclk), .rst_n(rst_n), .pulse(encPulse2),
          .clearCount(encWindow), .count(cnt2), .tooFast(fast2));
      end
    end
  endgenerate
  assign diff = (cnt1 > cnt2) ? {1'b0, cnt1 - cnt2} : {1'b0, cnt2 - cnt1};
  // tolerance plus 25 percent of it
  assign limit = {2'b00, encTolerance} + 18'({2'b00, encTolerance} *
    18'(`SFM_TOL_PCT) / 18'd100);
  function automatic logic restartBad(input sfm_res_t r, input logic lvl);
    restartBad = (r.lastLevel && !lvl &&
      (r.count < 16'(`SFM_RES_MIN_CYC))) ||
      (lvl && (r.count == 16'(`SFM_RES_MAX_CYC)));
  endfunction
  function automatic sfm_res_t restartStep(input sfm_res_t r,
                                           input logic lvl);
    sfm_res_t n;
    n = r;
    n.lastLevel = lvl;
    if (!lvl) begin
      n.count = 16'h0000;
    end else if (r.count != 16'(`SFM_RES_MAX_CYC)) begin
      n.count = r.count + 16'h0001;
    end
    restartStep = n;
  endfunction
  // ----------------------------------------------------------------
  // detection and code priority
  // ----------------------------------------------------------------
  always_comb begin
    sfm_code_t c;
    logic [3:0] pair;
    c = `SFM_CODE_NONE;
    st_d = st_q;
    pair = ~(dualFirst ^ dualSecond);
    st_d.pairBad = pair;
    st_d.lastFirst = dualFirst;
    // first cycle after reset has no valid previous input sample
    st_d.armed = 1'b1;
    st_d.resA = restartStep(st_q.resA, restart_input_ch_a);
    st_d.resB = restartStep(st_q.resB, restart_input_ch_b);
    st_d.lastOutA = safetyOutA;
    st_d.lastOutB = safetyOutB;
    // settle timers restart when an output switches
    if (safetyOutA != st_q.lastOutA) begin
      st_d.edmA = 16'h0000;
    end else if (st_q.edmA != 16'(`SFM_EDM_CYC)) begin
      st_d.edmA = st_q.edmA + 16'h0001;
    end
    if (safetyOutB != st_q.lastOutB) begin
      st_d.edmB = 16'h0000;
    end else if (st_q.edmB != 16'(`SFM_EDM_CYC)) begin
      st_d.edmB = st_q.edmB + 16'h0001;
    end
    st_d.sensMem = st_q.sensMem | sensorErr;
    st_d.intErr = st_q.intErr | internalErr;
    if (caseStrobe) begin
      st_d.lastCase = caseSelect;
    end
    // lower priority first, later lines override
    if (warnFieldObj) c = `SFM_CODE_WARN_FIELD;
    if (protFieldObj) c = `SFM_CODE_PROT_FIELD;
    if (st_q.edmA == 16'(`SFM_EDM_CYC)) begin
      if (safetyOutA && contactor_feedback_ch_a)
        c = `SFM_CODE_CONTACTOR_FEEDBACK_CH_A_CLOSED;
      if (!safetyOutA && !contactor_feedback_ch_a)
        c = `SFM_CODE_CONTACTOR_FEEDBACK_CH_A_OPENINACT;
    end
    if (st_q.edmB == 16'(`SFM_EDM_CYC)) begin
      if (safetyOutB && contactor_feedback_ch_b)
        c = `SFM_CODE_CONTACTOR_FEEDBACK_CH_B_CLOSED;
      if (!safetyOutB && !contactor_feedback_ch_b)
        c = `SFM_CODE_CONTACTOR_FEEDBACK_CH_B_OPENINACT;
    end
    // feedback must close shortly after the output drops
    if (st_q.edmA == 16'(`SFM_EDM_CYC) - 16'h0001 && !safetyOutA &&
        !contactor_feedback_ch_a) c = `SFM_CODE_CONTACTOR_FEEDBACK_CH_A_OPEN;
    if (st_q.edmB == 16'(`SFM_EDM_CYC) - 16'h0001 && !safetyOutB &&
        !contactor_feedback_ch_b) c = `SFM_CODE_CONTACTOR_FEEDBACK_CH_B_OPEN;
    if (fast1 || fast2) c = `SFM_CODE_ENC_FREQ;
    if (restartBad(st_q.resB, restart_input_ch_b))
      c = `SFM_CODE_RESTART_INPUT_CH_B;
    if (restartBad(st_q.resA, restart_input_ch_a))
      c = `SFM_CODE_RESTART_INPUT_CH_A;
    // valid pairs flipping together in one cycle count as faulty operation
    if (st_q.armed && (st_q.pairBad == 4'h0) && (pair == 4'h0) &&
        ($countones(dualFirst ^ st_q.lastFirst) > 1))
      c = `SFM_CODE_IN_OPER;
    for (int i = 3; i >= 0; i--) begin
      if (pair[i]) c = `SFM_CODE_PAIR0 + 8'(i);
    end
    if (caseStrobe && !allowedNext[caseSelect])
      c = `SFM_CODE_CASE_ORD;
    if (pair == 4'h0 && !definedCombos[dualFirst])
      c = `SFM_CODE_UNDEF_IN;
    if (encDir1 != encDir2) c = `SFM_CODE_ENC_DIR;
    if (encWindow && ({1'b0, diff} > limit)) c = `SFM_CODE_ENC_TOL;
    for (int i = 3; i >= 0; i--) begin
      if (sensorErr[i]) c = `SFM_CODE_SENSOR0 + 8'(i);
    end
    if (initFail[1]) c = `SFM_CODE_INIT_CH2;
    if (initFail[0]) c = `SFM_CODE_INIT_CH1;
    if (st_d.intErr[2]) c = `SFM_CODE_INT_C;
    if (st_d.intErr[1]) c = `SFM_CODE_INT_B;
    if (st_d.intErr[0]) c = `SFM_CODE_INT_A;
    // new detection wins over clear
    if (c != `SFM_CODE_NONE) begin
      st_d.code = c;
    end else if (clearFault) begin
      st_d.code = `SFM_CODE_NONE;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign faultCode = st_q.code;
  assign sensorMem = st_q.sensMem & (4'h1 << sensorQuery);
  assign latchedInternal = |st_q.intErr;
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_ENC_DIR: assert property (@(posedge mclk) disable iff (!rst_n)
    (encDir1 != encDir2) && initFail == 2'b00 && internalErr == 3'b000 &&
    st_q.intErr == 3'b000 && sensorErr == 4'h0 &&
    !(encWindow && ({1'b0, diff} > limit)) |=> faultCode == 8'ha2)
    else $error("direction mismatch not reported");
  AST_PAIR_A: assert property (@(posedge mclk) disable iff (!rst_n)
    (dualFirst[0] == dualSecond[0]) && initFail == 2'b00 &&
    internalErr == 3'b000 && st_q.intErr == 3'b000 &&
    sensorErr == 4'h0 && encDir1 == encDir2 &&
    !encWindow && !caseStrobe |=> faultCode == 8'hc8)
    else $error("equal pair A not reported");
  AST_INT_STICKY: assert property (@(posedge mclk) disable iff (!rst_n)
    internalErr[0] |=> latchedInternal [*8])
    else $error("internal error not held");
  AST_INT_CODE: assert property (@(posedge mclk) disable iff (!rst_n)
    internalErr[0] |=> faultCode == 8'ha0 [*3])
    else $error("internal error code not held");
  AST_INIT1: assert property (@(posedge mclk) disable iff (!rst_n)
    initFail[0] && internalErr == 3'b000 && st_q.intErr == 3'b000
    |=> faultCode == 8'h90)
    else $error("channel 1 init failure not reported");
  AST_SENSOR_MEM: assert property (@(posedge mclk) disable iff (!rst_n)
    sensorErr[2] |=> st_q.sensMem[2] [*8])
    else $error("sensor fault memory lost");
  AST_HOLD: assert property (@(posedge mclk) disable iff (!rst_n)
    !clearFault && $past(st_d.code) == st_q.code && st_d.code != st_q.code
    |-> st_d.code != 8'h00)
    else $error("fault code dropped without clear");
  AST_PROT: assert property (@(posedge mclk) disable iff (!rst_n)
    protFieldObj && st_d.code == 8'hf8 |=> faultCode == 8'hf8)
    else $error("protective field code not registered");
  AST_RES_LONG: assert property (@(posedge mclk) disable iff (!rst_n)
    st_q.resA.count == 16'(`SFM_RES_MAX_CYC) && restart_input_ch_a &&
    initFail == 2'b00 && internalErr == 3'b000 && st_q.intErr == 3'b000 &&
    sensorErr == 4'h0 && encDir1 == encDir2 &&
    !encWindow && !caseStrobe && dualFirst == st_q.lastFirst &&
    (dualFirst ^ dualSecond) == 4'hf && definedCombos[dualFirst]
    |=> faultCode == 8'hce)
    else $error("long restart pulse not reported");
  AST_IN_OPER: assert property (@(posedge mclk) disable iff (!rst_n)
    st_q.armed && st_q.pairBad == 4'h0 && (dualFirst ^ dualSecond) == 4'hf &&
    $countones(dualFirst ^ st_q.lastFirst) > 1 && definedCombos[dualFirst] &&
    !caseStrobe && encDir1 == encDir2 && !encWindow && sensorErr == 4'h0 &&
    initFail == 2'b00 && internalErr == 3'b000 && st_q.intErr == 3'b000
    |=> faultCode == 8'hcc)
    else $error("faulty input operation not reported");
  AST_CASE_ORD: assert property (@(posedge mclk) disable iff (!rst_n)
    caseStrobe && !allowedNext[caseSelect] && encDir1 == encDir2 &&
    !encWindow && sensorErr == 4'h0 && initFail == 2'b00 &&
    internalErr == 3'b000 && st_q.intErr == 3'b000 &&
    !((dualFirst ^ dualSecond) == 4'hf && !definedCombos[dualFirst])
    |=> faultCode == 8'ha5)
    else $error("wrong case order not reported");
  AST_CLEAR: assert property (@(posedge mclk) disable iff (!rst_n)
    clearFault && st_d.code == 8'h00 |=> faultCode == 8'h00)
    else $error("clear did not empty the fault code");
endmodule

/* verification/sfm_enc_model.sv */
// encoder model: periodic one-cycle pulses and a direction level
`timescale 1ns/1ps
module sfm_enc_model (
  input wire logic mclk,
  input wire logic [15:0] period,
  input wire logic dirIn,
  output logic pulse,
  output logic dir
);
  logic [15:0] cnt_q;
  assign dir = dirIn;
  initial begin
    pulse = 1'b0;
    cnt_q = 16'h0;
  end
  // period zero stops the wheel; otherwise one pulse each period cycles
  always @(posedge mclk) begin
    if (period == 16'h0) begin
      cnt_q <= 16'h0;
      pulse <= 1'b0;
    end else if (cnt_q + 16'h1 >= period) begin
      cnt_q <= 16'h0;
      pulse <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h1;
      pulse <= 1'b0;
    end
  end
endmodule

/* verification/sfm_monitor_test.sv */
// self-checking bench of the safety fault monitor
`timescale 1ns/1ps
module sfm_monitor_test;
  import sfm_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, caseStrobe = 1'b0, encWindow = 1'b0;
  logic [3:0] dualFirst = 4'h0, dualSecond = 4'hf, caseSelect = 4'h0;
  logic [15:0] definedCombos = 16'hffff, allowedNext = 16'hffff;
  logic [1:0] resIn = 2'h0, encDir = 2'h0, sOut = 2'h0, fb = 2'h3;
  logic [1:0] initFail = 2'h0, sensorQuery = 2'h0;
  logic [15:0] encTolerance = 16'hffff, per1 = 16'h0, per2 = 16'h0;
  logic protFieldObj = 1'b0, warnFieldObj = 1'b0, clearFault = 1'b0;
  logic [3:0] sensorErr = 4'h0, sensorMem;
  logic [2:0] internalErr = 3'h0;
  logic [7:0] faultCode;
  logic latchedInternal, p1, p2, d1, d2;
  int errors = 0, n_checks = 0, k;
  logic [31:0] seed = 32'hab45c0b1;
  logic [3:0] p;
  initial forever #25 mclk = ~mclk;
  sfm_enc_model u_sfm_enc_model_1 (.mclk(mclk), .period(per1),
    .dirIn(encDir[0]), .pulse(p1), .dir(d1));
  sfm_enc_model u_sfm_enc_model_2 (.mclk(mclk), .period(per2),
    .dirIn(encDir[1]), .pulse(p2), .dir(d2));
  sfm_monitor u_sfm_monitor (.mclk(mclk), .rst_n(rst_n),
    .dualFirst(dualFirst), .dualSecond(dualSecond),
    .definedCombos(definedCombos), .caseSelect(caseSelect),
    .allowedNext(allowedNext), .caseStrobe(caseStrobe),
    .restart_input_ch_a(resIn[0]), .restart_input_ch_b(resIn[1]),
    .encPulse1(p1), .encPulse2(p2), .encDir1(d1), .encDir2(d2),
    .encWindow(encWindow), .encTolerance(encTolerance),
    .contactor_feedback_ch_a(fb[0]), .contactor_feedback_ch_b(fb[1]),
    .safetyOutA(sOut[0]), .safetyOutB(sOut[1]),
    .protFieldObj(protFieldObj), .warnFieldObj(warnFieldObj),
    .sensorErr(sensorErr), .initFail(initFail),
    .internalErr(internalErr), .sensorQuery(sensorQuery),
    .clearFault(clearFault), .faultCode(faultCode),
    .sensorMem(sensorMem), .latchedInternal(latchedInternal));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic summarize;
    if (errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(logic [7:0] s, logic [7:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // bounded wait for a code, then compare
  task automatic waitCode(logic [7:0] e, int b);
    int i;
    #1;
    i = 0;
    while (faultCode !== e && i < b) begin
      tick(1);
      i++;
    end
    chk(faultCode, e);
  endtask
  task automatic clr;
    @(posedge mclk) clearFault <= 1'b1;
    @(posedge mclk) clearFault <= 1'b0;
    waitCode(8'h00, 4);
  endtask
  task automatic doReset;
    @(posedge mclk) rst_n <= 1'b0;
    tick(10);
    @(posedge mclk) rst_n <= 1'b1;
    tick(2);
    chk(faultCode, 8'h00);
    chk({4'h0, sensorMem}, 8'h00);
    chk({7'h0, latchedInternal}, 8'h00);
  endtask
  initial begin
    #5000000;
    errors++;
    summarize();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    doReset();
    for (k = 0; k < 4; k++) begin
      p = 4'($random(seed));
      @(posedge mclk) dualFirst <= p;
      dualSecond <= ~p ^ (4'h1 << k);
      waitCode(8'hc8 + 8'(k), 3);
      @(posedge mclk) dualSecond <= ~p;
      definedCombos <= ~(16'h1 << p);
      waitCode(8'ha3, 3);
      @(posedge mclk) definedCombos <= 16'hffff;
      clr();
      @(posedge mclk) sensorQuery <= 2'(k);
      sensorErr <= 4'h1 << k;
      @(posedge mclk) sensorErr <= 4'h0;
      waitCode(8'hb4 + 8'(k), 4);
      chk({4'h0, sensorMem}, 8'h1 << k);
      clr();
    end
    @(posedge mclk) dualFirst <= dualFirst ^ 4'h3;
    dualSecond <= dualSecond ^ 4'h3;
    waitCode(8'hcc, 3);
    clr();
    @(posedge mclk) protFieldObj <= 1'b1;
    waitCode(8'hf8, 3);
    @(posedge mclk) protFieldObj <= 1'b0;
    warnFieldObj <= 1'b1;
    waitCode(8'hf9, 3);
    @(posedge mclk) warnFieldObj <= 1'b0;
    for (k = 0; k < 2; k++) begin
      @(posedge mclk) initFail <= 2'h1 << k;
      waitCode(8'h90 + 8'(k), 3);
      @(posedge mclk) initFail <= 2'h0;
      clr();
      @(posedge mclk) resIn[k] <= 1'b1;
      tick(10);
      @(posedge mclk) resIn[k] <= 1'b0;
      waitCode(8'hce + 8'(2 * k), 8);
      clr();
      @(posedge mclk) sOut[k] <= 1'b1;
      waitCode(8'hf2 + 8'(4 * k), 2100);
      @(posedge mclk) fb[k] <= 1'b0;
      clr();
      @(posedge mclk) sOut[k] <= 1'b0;
      waitCode(8'hf0 + 8'(4 * k), 2100);
      waitCode(8'hf3 + 8'(4 * k), 4);
      @(posedge mclk) fb[k] <= 1'b1;
      tick(2100);
      clr();
    end
    @(posedge mclk) encDir <= 2'h1;
    waitCode(8'ha2, 3);
    @(posedge mclk) encDir <= 2'h0;
    caseSelect <= 4'h5;
    allowedNext <= 16'hffdf;
    caseStrobe <= 1'b1;
    @(posedge mclk) caseStrobe <= 1'b0;
    waitCode(8'ha5, 3);
    @(posedge mclk) allowedNext <= 16'hffff;
    per1 <= 16'h0064;
    waitCode(8'hd1, 400);
    @(posedge mclk) per1 <= 16'h0190;
    tick(3);
    clr();
    tick(900);
    chk(faultCode, 8'h00);
    @(posedge mclk) encWindow <= 1'b1;
    @(posedge mclk) encWindow <= 1'b0;
    per1 <= 16'h012c;
    tick(3100);
    chk(faultCode, 8'h00);
    @(posedge mclk) encTolerance <= 16'h0004;
    encWindow <= 1'b1;
    @(posedge mclk) encWindow <= 1'b0;
    per1 <= 16'h0;
    waitCode(8'ha1, 4);
    clr();
    for (k = 0; k < 3; k++) begin
      @(posedge mclk) internalErr <= 3'h1 << k;
      @(posedge mclk) internalErr <= 3'h0;
      waitCode(k == 0 ? 8'ha0 : (k == 1 ? 8'ha4 : 8'hfa), 3);
      @(posedge mclk) clearFault <= 1'b1;
      @(posedge mclk) clearFault <= 1'b0;
      tick(3);
      chk(faultCode, k == 0 ? 8'ha0 : (k == 1 ? 8'ha4 : 8'hfa));
      chk({7'h0, latchedInternal}, 8'h01);
      doReset();
    end
    summarize();
  end
endmodule
